// file: pkg/pbg_pkg.sv
package pbg_pkg;
	// register offsets
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_PORT = 4'h0;
	localparam logic [3:0] OFF_LATCH = 4'h1;
	localparam logic [3:0] OFF_DIR = 4'h2;
	localparam logic [3:0] OFF_PULLUP = 4'h3;
	localparam logic [3:0] OFF_CHG_EN = 4'h4;
	localparam logic [3:0] OFF_CTRL = 4'h5;
	localparam logic [3:0] OFF_ANALOG = 4'h6;
	// control register fields
	localparam int CTRL_MASTER_BIT = 0;
	localparam int CTRL_FLAG_BIT = 1;
	localparam int CTRL_PU_DIS_BIT = 7;
	// pin map
	localparam int PORT_W = 8;
	localparam int ANALOG_W = 5;
	localparam int CHG_LO = 4;
	localparam int CHG_W = 4;
	localparam int LVP_PIN = 5;
	localparam int CCP_PIN = 3;
	// reset values
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [3:0] RST_CHG_EN = 4'h0;
	localparam logic [4:0] RST_ANALOG = 5'h1F;
	localparam logic [4:0] DIGITAL_ALL = 5'h00;
	localparam logic [3:0] RST_SNAP = 4'h0;
	localparam logic RST_PU_DIS = 1'b1;
	localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// file: design/pbg_port.sv
`timescale 1ns/100ps
// Summary of operation
// - eight pins, each input or output
// - direction one is input, zero drives latch
// - latch register reads back latched value
// - pull-up needs enable bit and global enable
// - global disable turns every pull-up off
// - output pins get no pull-up, except pin three when the capture output drives it
// - power-on reset disables all pull-ups
// - low five pins analog after power-on
// - default select one makes them digital
// - upper four pins have change enables
// - master enable gates all change enables
// - output pins excluded from change compare
// - pins compared with last-read snapshot, ORed
// - change flag can wake the device
// - port access refreshes snapshot, except move
// - mismatch keeps setting flag until refreshed
// - snapshot survives external and brown-out reset
// - change at refresh cycle may be missed
// - capture pin moves here when select zero
// - analog disables port input, not output or capture input
// - programming enable makes pin five entry only
module pbg_port
	import pbg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic warm_reset,
	input wire logic [pbg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_move,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pullup_on,
	input wire logic analog_default_select,
	input wire logic alt_capture_pin_select,
	input wire logic low_voltage_program_enable,
	input wire logic ccp_out,
	input wire logic ccp_oe,
	output logic ccp_capture_in,
	output logic lvp_entry_pin,
	output logic change_int_flag,
	output logic wake_q
);
	import pbg_pkg::*;

	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	logic [7:0] latch_q;
	logic [7:0] dir_q;
	logic [7:0] pullup_q;
	logic [3:0] chg_en_q;
	logic master_q;
	logic pu_dis_q;
	logic flag_q;
	logic [4:0] analog_q;
	logic init_done_q;
	logic [3:0] snap_q;
	logic [7:0] digital_in;
	logic [3:0] mismatch;
	logic [3:0] cmp_mask;
	logic any_mismatch;
	logic port_touch;
	logic flag_clear;
	logic ccp_here;
	logic lvp_on;
	logic [7:0] out_d;
	logic [7:0] oe_d;
	logic [7:0] pu_d;
	logic [7:0] rdata_d;

	// pin synchroniser
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1_q <= READ_ZERO;
			sync2_q <= READ_ZERO;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	assign lvp_on = low_voltage_program_enable;
	assign ccp_here = !alt_capture_pin_select;

	// digital input view of the pins
	always_comb
	begin
		digital_in = sync2_q;
		digital_in[ANALOG_W-1:0] = sync2_q[ANALOG_W-1:0] & ~analog_q;
		if (lvp_on)
		begin
			digital_in[LVP_PIN] = 1'b0;
		end
	end

	// software access decode
	assign port_touch = (reg_wr || reg_rd) && reg_addr == OFF_PORT && !reg_move;
	assign flag_clear = reg_wr && reg_addr == OFF_CTRL && !reg_wdata[CTRL_FLAG_BIT];

	// output latch
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			latch_q <= RST_LATCH;
		end
		else if (warm_reset)
		begin
			latch_q <= RST_LATCH;
		end
		else if (reg_wr && (reg_addr == OFF_PORT || reg_addr == OFF_LATCH))
		begin
			latch_q <= reg_wdata;
		end
	end

	// direction bits
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dir_q <= RST_DIR;
		end
		else if (warm_reset)
		begin
			dir_q <= RST_DIR;
		end
		else if (reg_wr && reg_addr == OFF_DIR)
		begin
			dir_q <= reg_wdata;
		end
	end

	// pull-up enables and global disable
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pullup_q <= RST_PULLUP;
			pu_dis_q <= RST_PU_DIS;
		end
		else if (warm_reset)
		begin
			pullup_q <= RST_PULLUP;
			pu_dis_q <= RST_PU_DIS;
		end
		else
		begin
			if (reg_wr && reg_addr == OFF_PULLUP)
			begin
				pullup_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == OFF_CTRL)
			begin
				pu_dis_q <= reg_wdata[CTRL_PU_DIS_BIT];
			end
		end
	end

	// change enables and master enable, kept over warm reset so the flag can re-set
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chg_en_q <= RST_CHG_EN;
			master_q <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == OFF_CHG_EN)
			begin
				chg_en_q <= reg_wdata[CHG_LO +: CHG_W];
			end
			if (reg_wr && reg_addr == OFF_CTRL)
			begin
				master_q <= reg_wdata[CTRL_MASTER_BIT];
			end
		end
	end

	// analog select, default caught once after power-on release
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			analog_q <= RST_ANALOG;
			init_done_q <= 1'b0;
		end
		else if (!init_done_q)
		begin
			init_done_q <= 1'b1;
			analog_q <= analog_default_select ? DIGITAL_ALL : RST_ANALOG;
		end
		else if (reg_wr && reg_addr == OFF_ANALOG)
		begin
			analog_q <= reg_wdata[ANALOG_W-1:0];
		end
	end

	// last-read snapshot, untouched by warm reset
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			snap_q <= RST_SNAP;
		end
		else if (port_touch)
		begin
			snap_q <= digital_in[CHG_LO +: CHG_W];
		end
	end

	// mismatch compare on enabled input pins
	always_comb
	begin
		cmp_mask = chg_en_q & dir_q[CHG_LO +: CHG_W];
		if (lvp_on)
		begin
			cmp_mask[LVP_PIN-CHG_LO] = 1'b0;
		end
		if (!master_q)
		begin
			cmp_mask = 4'h0;
		end
		mismatch = (digital_in[CHG_LO +: CHG_W] ^ snap_q) & cmp_mask;
		// a refresh in this cycle hides a coincident change
		if (port_touch)
		begin
			mismatch = 4'h0;
		end
	end

	assign any_mismatch = |mismatch;

	// sticky change flag, set wins over clear
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			flag_q <= 1'b0;
		end
		else if (warm_reset)
		begin
			flag_q <= 1'b0;
		end
		else if (any_mismatch)
		begin
			flag_q <= 1'b1;
		end
		else if (flag_clear)
		begin
			flag_q <= 1'b0;
		end
	end

	// pin drive, enables and pull-ups
	always_comb
	begin
		out_d = latch_q;
		oe_d = ~dir_q;
		if (ccp_here && ccp_oe)
		begin
			out_d[CCP_PIN] = ccp_out;
			oe_d[CCP_PIN] = 1'b1;
		end
		pu_d = pullup_q & dir_q;
		if (pu_dis_q)
		begin
			pu_d = 8'h00;
		end
		if (lvp_on)
		begin
			oe_d[LVP_PIN] = 1'b0;
			out_d[LVP_PIN] = 1'b0;
			pu_d[LVP_PIN] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_out <= RST_LATCH;
			pin_oe <= 8'h00;
			pullup_on <= 8'h00;
		end
		else
		begin
			pin_out <= out_d;
			pin_oe <= oe_d;
			pullup_on <= pu_d;
		end
	end

	// peripheral-facing inputs and status outputs
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ccp_capture_in <= 1'b0;
			lvp_entry_pin <= 1'b0;
			change_int_flag <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			ccp_capture_in <= ccp_here ? sync2_q[CCP_PIN] : 1'b0;
			lvp_entry_pin <= lvp_on ? sync2_q[LVP_PIN] : 1'b0;
			change_int_flag <= flag_q;
			wake_q <= flag_q && master_q;
		end
	end

	// read mux
	always_comb
	begin
		rdata_d = READ_ZERO;
		case (reg_addr)
			OFF_PORT:
			begin
				rdata_d = digital_in;
			end
			OFF_LATCH:
			begin
				rdata_d = latch_q;
			end
			OFF_DIR:
			begin
				rdata_d = dir_q;
			end
			OFF_PULLUP:
			begin
				rdata_d = pullup_q;
			end
			OFF_CHG_EN:
			begin
				rdata_d = {chg_en_q, 4'h0};
			end
			OFF_CTRL:
			begin
				rdata_d[CTRL_MASTER_BIT] = master_q;
				rdata_d[CTRL_FLAG_BIT] = flag_q;
				rdata_d[CTRL_PU_DIS_BIT] = pu_dis_q;
			end
			OFF_ANALOG:
			begin
				rdata_d = {3'h0, analog_q};
			end
			default:
			begin
				rdata_d = READ_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reg_rdata <= READ_ZERO;
		end
		else if (reg_rd)
		begin
			reg_rdata <= rdata_d;
		end
		else
		begin
			reg_rdata <= READ_ZERO;
		end
	end

endmodule

// file: bench/pbg_pins_model.sv
`timescale 1ns/100ps
module pbg_pins_model
(
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_level
);
	// driven pins carry pin_out, released pins the far side level
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// file: bench/pbg_port_properties.sv
`timescale 1ns/100ps
module pbg_port_properties
	import pbg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic warm_reset,
	input wire logic [pbg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_on,
	input wire logic change_int_flag,
	input wire logic wake_q
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	a_pu_por: assert property ($rose(reset_n) |-> (pullup_on == 8'h00) [*2])
		else $error("pull-up on after reset");
	a_pu_global: assert property (reg_wr && reg_addr == OFF_CTRL && reg_wdata[7]
		|-> ##2 pullup_on == 8'h00) else $error("pull-up on when disabled");
	a_pu_output: assert property ((pullup_on & pin_oe & 8'hF7) == 8'h00)
		else $error("pull-up on output pin");
	a_dir_drive: assert property (reg_wr && reg_addr == OFF_DIR |-> ##2
		(pin_oe & 8'hF7) == (~$past(reg_wdata, 2) & 8'hF7)) else $error("pin_oe wrong");
	a_latch_drive: assert property (reg_wr && reg_addr == OFF_LATCH |-> ##2
		(pin_out & 8'hF7) == ($past(reg_wdata, 2) & 8'hF7)) else $error("pin_out wrong");
	a_latch_read: assert property (reg_rd && reg_addr == OFF_LATCH |=>
		(reg_rdata & 8'hF7) == (pin_out & 8'hF7)) else $error("latch read wrong");
	a_flag_sticky: assert property ($fell(change_int_flag) |-> $past(warm_reset)
		|| $past(warm_reset, 2) || $past(reg_wr, 2) && $past(reg_addr, 2) == OFF_CTRL
		&& ($past(reg_wdata, 2) & 8'h02) == 8'h00) else $error("flag lost");
	a_wake_flag: assert property (wake_q |-> change_int_flag)
		else $error("wake without flag");
	cover property (wake_q);
	cover property ($fell(change_int_flag));
	cover property (reg_rd && reg_addr == OFF_LATCH);
endmodule
bind pbg_port pbg_port_properties u_props (.clk_sys, .reset_n, .warm_reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_out, .pin_oe, .pullup_on,
	.change_int_flag, .wake_q);

// file: bench/pbg_port_tb.sv
`timescale 1ns/100ps
module pbg_port_tb;
	import pbg_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_move = 1'b0;
	logic ads = 1'b0;
	logic warm_reset = 1'b0;
	logic alt_sel = 1'b0;
	logic lvp_en = 1'b0;
	logic ccp_o = 1'b0;
	logic ccp_e = 1'b0;
	logic ccp_cap;
	logic lvp_pin;
	logic [7:0] ext_val = 8'hFF;
	logic [7:0] reg_rdata, pin_out, pin_oe, pullup_on, pin_level;
	logic change_int_flag, wake_q;
	int bad_count = 0;
	int total_checks = 0;
	always #50 clk_sys = ~clk_sys;
	pbg_port dut (.clk_sys, .reset_n, .warm_reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_move, .reg_rdata, .pin_in(pin_level), .pin_out, .pin_oe, .pullup_on,
		.analog_default_select(ads), .alt_capture_pin_select(alt_sel),
		.low_voltage_program_enable(lvp_en), .ccp_out(ccp_o), .ccp_oe(ccp_e),
		.ccp_capture_in(ccp_cap), .lvp_entry_pin(lvp_pin), .change_int_flag, .wake_q);
	pbg_pins_model pins (.pin_out, .pin_oe, .ext_val, .pin_level);
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
		@(posedge clk_sys);
	endtask
	task automatic flag_is(input logic [7:0] e);
		repeat (6) @(posedge clk_sys);
		chk("change_int_flag", e, {7'h00, change_int_flag});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(OFF_DIR, 8'hFF);
		rd(OFF_PULLUP, 8'h00);
		rd(OFF_CTRL, 8'h80);
		rd(OFF_ANALOG, 8'h1F);
		rd(OFF_PORT, 8'hE0);
		rd(4'h9, 8'h00);
		$display("reset test done");
		wr(OFF_PULLUP, 8'hFF);
		wr(OFF_CTRL, 8'h00);
		@(posedge clk_sys);
		chk("pullup_on", 8'hFF, pullup_on);
		wr(OFF_DIR, 8'h0F);
		@(posedge clk_sys);
		chk("pullup_on", 8'h0F, pullup_on);
		wr(OFF_CTRL, 8'h80);
		@(posedge clk_sys);
		chk("pullup_on", 8'h00, pullup_on);
		$display("pull-up test done");
		wr(OFF_LATCH, 8'hA5);
		rd(OFF_LATCH, 8'hA5);
		chk("pin_out", 8'hA0, pin_out & pin_oe);
		wr(OFF_ANALOG, 8'h00);
		ext_val <= 8'h3C;
		repeat (3) @(posedge clk_sys);
		rd(OFF_PORT, 8'hAC);
		$display("port test done");
		wr(OFF_CHG_EN, 8'hF0);
		wr(OFF_CTRL, 8'h81);
		wr(OFF_LATCH, 8'h55);
		flag_is(8'h00);
		wr(OFF_CTRL, 8'h80);
		wr(OFF_DIR, 8'hFF);
		flag_is(8'h00);
		wr(OFF_CTRL, 8'h81);
		flag_is(8'h01);
		chk("wake_q", 8'h01, {7'h00, wake_q});
		wr(OFF_CTRL, 8'h81);
		flag_is(8'h01);
		reg_move <= 1'b1;
		rd(OFF_PORT, 8'h3C);
		reg_move <= 1'b0;
		wr(OFF_CTRL, 8'h81);
		flag_is(8'h01);
		rd(OFF_PORT, 8'h3C);
		wr(OFF_CTRL, 8'h81);
		flag_is(8'h00);
		ext_val <= 8'h7C;
		flag_is(8'h01);
		ext_val <= 8'h3C;
		flag_is(8'h01);
		wr(OFF_CTRL, 8'h83);
		flag_is(8'h01);
		wr(OFF_CTRL, 8'h81);
		flag_is(8'h00);
		$display("change test done");
		warm_reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		warm_reset <= 1'b0;
		flag_is(8'h00);
		rd(OFF_LATCH, 8'h00);
		rd(OFF_DIR, 8'hFF);
		ext_val <= 8'h7C;
		warm_reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		warm_reset <= 1'b0;
		flag_is(8'h01);
		rd(OFF_PORT, 8'h7C);
		wr(OFF_CTRL, 8'h80);
		flag_is(8'h00);
		$display("warm reset test done");
		wr(OFF_ANALOG, 8'h1F);
		wr(OFF_PULLUP, 8'hFF);
		wr(OFF_CTRL, 8'h00);
		ccp_e <= 1'b1;
		ccp_o <= 1'b1;
		lvp_en <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("pin_oe", 8'h08, pin_oe);
		chk("pin_out", 8'h08, pin_out);
		chk("pullup_on", 8'hDF, pullup_on);
		chk("ccp_capture_in", 8'h01, {7'h00, ccp_cap});
		chk("lvp_entry_pin", 8'h01, {7'h00, lvp_pin});
		rd(OFF_PORT, 8'h40);
		alt_sel <= 1'b1;
		lvp_en <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("pin_oe", 8'h00, pin_oe);
		chk("ccp_capture_in", 8'h00, {7'h00, ccp_cap});
		chk("lvp_entry_pin", 8'h00, {7'h00, lvp_pin});
		$display("pin function test done");
		reset_n <= 1'b0;
		ads <= 1'b1;
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(OFF_ANALOG, 8'h00);
		$display("config test done");
		complete_run();
	end
endmodule
